// *** pad_config_pkg.sv ***
// constants, register layout and carrier types of the pad configuration unit
package pad_config_pkg;

  localparam int  NUM_PINS   = 18;
  localparam int  NUM_SLOTS  = 19;
  localparam int  NUM_FCLK   = 7;
  localparam int  ADDR_W     = 12;

  // register byte offsets, one aligned word per pin
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N17      = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N13      = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N12      = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N5       = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N4       = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N3       = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N2       = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N11_TRUOD = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N10_TRUOD = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N16      = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N15      = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N1       = 12'h02c;
  localparam logic [ADDR_W-1:0] OFF_RESERVED        = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N9       = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N8       = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N7       = 12'h03c;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N6       = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N0       = 12'h044;
  localparam logic [ADDR_W-1:0] OFF_CFG_P0_N14      = 12'h048;
  localparam logic [ADDR_W-1:0] OFF_LAST            = OFF_CFG_P0_N14;

  // pin number held in each word slot, 5'h1f marks the reserved slot
  localparam logic [4:0] SLOT_NONE = 5'h1f;
  localparam logic [4:0] SLOT_PIN [NUM_SLOTS] = '{
    5'h11, 5'h0d, 5'h0c, 5'h05, 5'h04, 5'h03, 5'h02, 5'h0b, 5'h0a, 5'h10,
    5'h0f, 5'h01, 5'h1f, 5'h09, 5'h08, 5'h07, 5'h06, 5'h00, 5'h0e};

  // the two true open-drain bus pads
  localparam int  BUS_PAD_A  = 10;
  localparam int  BUS_PAD_B  = 11;

  // field positions
  localparam int  MODE_LSB   = 3;
  localparam int  MODE_MSB   = 4;
  localparam int  HYS_BIT    = 5;
  localparam int  INV_BIT    = 6;
  localparam int  POD_BIT    = 10;
  localparam int  SMODE_LSB  = 11;
  localparam int  SMODE_MSB  = 12;
  localparam int  CDIV_LSB   = 13;
  localparam int  CDIV_MSB   = 15;

  // reset values and writable bits
  localparam logic [31:0] RESET_STD   = 32'h0000_0090;
  localparam logic [31:0] RESET_BUS   = 32'h0000_0080;
  localparam logic [31:0] WMASK_STD   = 32'h0000_fc78;
  localparam logic [31:0] WMASK_BUS   = 32'h0000_ff78;

  // pull control encodings
  localparam logic [1:0] PULL_NONE    = 2'h0;
  localparam logic [1:0] PULL_DOWN    = 2'h1;
  localparam logic [1:0] PULL_UP      = 2'h2;
  localparam logic [1:0] PULL_REPEAT  = 2'h3;

  localparam logic [1:0] SMODE_BYPASS = 2'h0;
  localparam logic [2:0] CDIV_RSVD    = 3'h7;

  // drive towards one pad
  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
    logic hysteresis_enable;
    logic analog_mode;
    logic drive_level;
    logic drive_oe_b;
  } pad_drive_t;

  // request of the gpio or peripheral function routed to a pad
  typedef struct packed {
    logic out_level;
    logic out_enable;
  } func_req_t;

endpackage : pad_config_pkg

// *** pad_config_unit.sv ***
// pad configuration unit: apb register bank, pad control and glitch filters
// How it works
// RL1 - software gates bus clock on first
// RL2 - pull-up on after reset, bus pads none
// RL3 - repeater pulls toward the sensed level
// RL4 - pseudo open-drain only drives low
// RL5 - analog select forces analog pad mode
// RL6 - bus pads always true open-drain, filterable
// RL7 - filter rejects pulses below sample count
// RL8 - each pin picks one of seven ticks
// RL9 - bypass passes pin with no sampling
// RL10 - level passes after count plus one
// RL11 - threshold-plus-one pulses may be rejected
// RL12 - software keeps filter off when fast
// RL13 - software trades clock rate and count
// RL14 - one read-write word per pin
// RL15 - reset values 0x90 and 0x80
// RL16 - unbonded pins read as reserved
// RL17 - software parks unbonded bus pads low
// RL18 - pull field encodes none/down/up/repeat
// RL19 - sample count zero bypasses filter
// RL20 - clock select 0..6, seven reserved
// RL21 - invert, hysteresis and open-drain bits
// RL22 - candidate restarts counter on change
// RL23 - pin synchronised before counting
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module pad_config_unit
  import pad_config_pkg::*;
#(
  parameter logic [17:0] PIN_BONDED = 18'h3ffff
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pad_config_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic                               pready,
  output logic                               pslverr,
  output logic [31:0]                        prdata,
  // divided filter clock ticks, one clk cycle each
  input  wire logic [pad_config_pkg::NUM_FCLK-1:0] filter_clock_n,
  // switch matrix side
  input  wire pad_config_pkg::func_req_t [17:0] func_req,
  input  wire logic [17:0]                   analog_select,
  output logic [17:0]                        core_in,
  // pad side
  input  wire logic [17:0]                   pad_in,
  output pad_config_pkg::pad_drive_t [17:0]  pad_drive
);
  import pad_config_pkg::*;

  // configuration words indexed by pin number
  logic [31:0] cfg       [NUM_PINS];
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic [17:0] cand;
  logic [1:0]  stable_cnt [NUM_PINS];
  logic [17:0] filt_out;

  // decode of the addressed slot
  function automatic logic [4:0] slot_to_pin(input logic [ADDR_W-1:0] addr);
    logic [4:0] pin;
    pin = SLOT_NONE;
    if (addr[1:0] == 2'h0 && addr <= OFF_LAST) begin
      pin = SLOT_PIN[addr[6:2]];
    end
    return pin;
  endfunction : slot_to_pin

  function automatic logic is_bus_pad(input int idx);
    return (idx == BUS_PAD_A) || (idx == BUS_PAD_B);
  endfunction : is_bus_pad

  // byte-lane merge under strobes and writable mask
  function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old_w & ~m) | (new_w & m);
  endfunction : merge_word

  // bus decode
  wire logic [4:0] sel_pin   = slot_to_pin(paddr);
  wire logic       sel_valid = (sel_pin != SLOT_NONE) && PIN_BONDED[sel_pin]; // RL16
  wire logic       setup_ph  = psel && !penable;
  wire logic       wr_take   = psel && penable && pwrite && sel_valid;
  wire logic [31:0] rd_word  = sel_valid ? cfg[sel_pin] : 32'h0000_0000; // RL14

  // zero-wait slave, reserved words answer zero without error
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // read data registered in the setup cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // two-flop synchroniser of pad inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 18'h3ffff;
      sync2 <= 18'h3ffff;
    end else begin
      sync1 <= pad_in; // RL23
      sync2 <= sync1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      localparam logic BUS = is_bus_pad(gi);
      localparam logic [31:0] RST_V = BUS ? RESET_BUS : RESET_STD;
      localparam logic [31:0] WMSK  = BUS ? WMASK_BUS : WMASK_STD;

      // field decode of this pin
      wire logic [1:0] pull_mode = cfg[gi][MODE_MSB:MODE_LSB];
      wire logic [1:0] smode     = cfg[gi][SMODE_MSB:SMODE_LSB];
      wire logic [2:0] cdiv      = cfg[gi][CDIV_MSB:CDIV_LSB];
      wire logic       input_invert       = cfg[gi][INV_BIT]; // RL21
      wire logic       pod       = cfg[gi][POD_BIT]; // RL21
      wire logic       bypass    = (smode == SMODE_BYPASS); // RL19
      wire logic       tick      = (cdiv != CDIV_RSVD) && filter_clock_n[cdiv]; // RL8 RL20
      wire logic       sample    = sync2[gi];
      wire logic       differs   = (sample != cand[gi]);
      // first differing tick counts as edge one, so smode further edges complete the level
      wire logic       done      = !differs && (stable_cnt[gi] == smode - 2'h1); // RL10

      // configuration word, writable bits only
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg[gi] <= RST_V; // RL15 RL2
        end else if (wr_take && sel_pin == 5'(gi)) begin
          cfg[gi] <= merge_word(cfg[gi], pwdata, pstrb, WMSK); // RL14
        end
      end

      // stable-sample counter on the selected filter tick
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cand[gi]       <= 1'b1;
          stable_cnt[gi] <= 2'h0;
          filt_out[gi]   <= 1'b1;
        end else if (bypass) begin
          cand[gi]       <= sample;
          stable_cnt[gi] <= 2'h0;
          filt_out[gi]   <= sample;
        end else if (tick) begin
          if (differs) begin
            cand[gi]       <= sample; // RL22
            stable_cnt[gi] <= 2'h0; // RL22
          end else if (done) begin
            filt_out[gi]   <= cand[gi]; // RL10 RL7
          end else begin
            stable_cnt[gi] <= stable_cnt[gi] + 2'h1; // RL10
          end
        end
      end

      // level seen by internal logic, bypass is a straight path
      assign core_in[gi] = (bypass ? pad_in[gi] : filt_out[gi]) ^ input_invert; // RL9 RL21 RL6

      // output drive: bus pads true open-drain, others optional pseudo open-drain
      wire logic od_mode  = BUS ? 1'b1 : pod; // RL4 RL6
      wire logic drive_en = func_req[gi].out_enable && !analog_select[gi] &&
                            (od_mode ? !func_req[gi].out_level : 1'b1); // RL4
      wire logic repeat_m = (pull_mode == PULL_REPEAT);

      assign pad_drive[gi].drive_oe_b   = !drive_en;
      assign pad_drive[gi].drive_level  = od_mode ? 1'b0 : func_req[gi].out_level; // RL4
      assign pad_drive[gi].analog_mode  = analog_select[gi]; // RL5
      assign pad_drive[gi].hysteresis_enable = cfg[gi][HYS_BIT]; // RL21
      // pull resistors; bus pads have none, analog disables them
      assign pad_drive[gi].pull_up_en   = !BUS && !analog_select[gi] &&
                                          ((pull_mode == PULL_UP) ||
                                           (repeat_m && sample)); // RL18 RL3 RL2
      assign pad_drive[gi].pull_down_en = !BUS && !analog_select[gi] &&
                                          ((pull_mode == PULL_DOWN) ||
                                           (repeat_m && !sample)); // RL18 RL3
    end
  endgenerate

endmodule : pad_config_unit

`default_nettype wire

// *** pad_config_unit_props.sv ***
// assertions on the ports of the pad configuration unit
`timescale 1ns/1ns
`default_nettype none
module pad_config_unit_props
  import pad_config_pkg::*;
(
  // clock, reset and bus
  input wire logic                               clk,
  input wire logic                               rst_b,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [31:0]                        prdata,
  // filter, switch matrix and pads
  input wire logic [pad_config_pkg::NUM_FCLK-1:0] filter_clock_n,
  input wire pad_config_pkg::func_req_t [17:0]   func_req,
  input wire logic [17:0]                        analog_select,
  input wire logic [17:0]                        core_in,
  input wire logic [17:0]                        pad_in,
  input wire pad_config_pkg::pad_drive_t [17:0]  pad_drive
);
  wire wr = psel & penable & pwrite; // register write strobe
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // pad control, read data and filter relations
  property p_reset_pull; $rose(rst_b) |-> pad_drive[0].pull_up_en && !pad_drive[10].pull_up_en; endproperty
  a_reset_pull: assert property (p_reset_pull) else $error("pull-up state wrong after reset");
  property p_bus_pull; !(pad_drive[10].pull_up_en | pad_drive[10].pull_down_en | pad_drive[11].pull_up_en | pad_drive[11].pull_down_en); endproperty
  a_bus_pull: assert property (p_bus_pull) else $error("bus pad has a pull enabled");
  property p_bus_od; !analog_select[11] |-> !pad_drive[11].drive_level && pad_drive[11].drive_oe_b == !(func_req[11].out_enable && !func_req[11].out_level); endproperty
  a_bus_od: assert property (p_bus_od) else $error("bus pad not open-drain");
  property p_analog; analog_select[0] |-> pad_drive[0].analog_mode && pad_drive[0].drive_oe_b && !pad_drive[0].pull_up_en; endproperty
  a_analog: assert property (p_analog) else $error("analog select not honoured");
  property p_pull_excl; !(pad_drive[0].pull_up_en && pad_drive[0].pull_down_en); endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_oe_idle; !func_req[0].out_enable |-> pad_drive[0].drive_oe_b; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pad driven without request");
  property p_read_hold; psel && penable && !pwrite |=> $stable(prdata) || (psel && !penable && !pwrite); endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved after access");
  property p_core_hold; $past(filter_clock_n) == '0 && !$past(wr) && $stable(pad_in) |-> $stable(core_in); endproperty
  a_core_hold: assert property (p_core_hold) else $error("core input moved without cause");
endmodule : pad_config_unit_props
bind pad_config_unit pad_config_unit_props u_props (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .filter_clock_n(filter_clock_n),
  .func_req(func_req), .analog_select(analog_select), .core_in(core_in), .pad_in(pad_in),
  .pad_drive(pad_drive));
`default_nettype wire

// *** pad_world.sv ***
// model of the board pins around the pad configuration unit
`timescale 1ns/1ns
`default_nettype none
module pad_world
  import pad_config_pkg::*;
(
  // clock and board drive
  input  wire logic                              clk,
  input  wire logic [17:0]                       ext_en,
  input  wire logic [17:0]                       ext_level,
  // pad side
  input  wire pad_config_pkg::pad_drive_t [17:0] pad_drive,
  output logic [17:0]                            pad_in
);
  logic flip = 1'b0;
  // floating pads show a level that changes every cycle
  always @(posedge clk) flip <= !flip;
  // pad level from chip drive, board drive, then pulls
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (!pad_drive[i].drive_oe_b) pad_in[i] = pad_drive[i].drive_level;
      else if (ext_en[i]) pad_in[i] = ext_level[i];
      else if (pad_drive[i].pull_up_en || i == BUS_PAD_A || i == BUS_PAD_B) pad_in[i] = 1'b1;
      else if (pad_drive[i].pull_down_en) pad_in[i] = 1'b0;
      else pad_in[i] = flip;
    end
  end
endmodule : pad_world
`default_nettype wire

// *** pad_config_unit_tb.sv ***
// self-checking bench of the pad configuration unit
`timescale 1ns/1ns
`default_nettype none
module pad_config_unit_tb;
  import pad_config_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, bad, cur, bus;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, rv, mk;
  logic [3:0] pstrb;
  logic [4:0] pin;
  logic [NUM_FCLK-1:0] ticks = '0;
  func_req_t [17:0] func_req;
  logic [17:0] analog_select, core_in, pad_in, ext_en, ext_level;
  pad_drive_t [17:0] pad_drive;
  logic [1:0] pull_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  int errors, check_count, s, p;
  int cyc = 0;
  pad_config_unit dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .filter_clock_n(ticks), .func_req(func_req), .analog_select(analog_select),
    .core_in(core_in), .pad_in(pad_in), .pad_drive(pad_drive));
  pad_world world (.clk(clk), .ext_en(ext_en), .ext_level(ext_level), .pad_drive(pad_drive),
    .pad_in(pad_in));
  initial begin
    clk = 0;
    forever #5 clk = !clk;
  end
  // filter ticks, clock k pulses every 4*(k+1) cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < NUM_FCLK; k++) ticks[k] <= (cyc % (4 * (k + 1))) == 0;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) errors++;
    rd = prdata;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic mon(input int n, input logic lvl);
    repeat (n) begin @(posedge clk); if (core_in[0] !== lvl) bad = 1; end
  endtask : mon
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = 4'hf;
    func_req = '0; analog_select = '0; ext_en = '0; ext_level = '0;
    errors = 0; check_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    // reset values, writable bits, reserved word
    for (int i = 0; i < NUM_SLOTS; i++) begin
      pin = SLOT_PIN[i];
      bus = pin == BUS_PAD_A || pin == BUS_PAD_B;
      rv = (pin == SLOT_NONE) ? '0 : bus ? RESET_BUS : RESET_STD;
      mk = (pin == SLOT_NONE) ? '0 : bus ? WMASK_BUS : WMASK_STD;
      apb(0, ADDR_W'(i * 4), '0);
      check(rd, rv, "reset word");
      apb(1, ADDR_W'(i * 4), '1);
      apb(0, ADDR_W'(i * 4), '0);
      check(rd, mk | (rv & ~mk), "written word");
    end
    apb(0, OFF_LAST + 12'h004, '0);
    check(rd, '0, "unmapped word");
    $display("test register map done");
    // pull encodings and repeater hold
    ext_en[0] <= 1; ext_level[0] <= 1;
    for (int m = 0; m < 4; m++) begin
      apb(1, OFF_CFG_P0_N0, 32'(m) << MODE_LSB);
      repeat (3) @(posedge clk);
      check({pad_drive[0].pull_up_en, pad_drive[0].pull_down_en}, pull_exp[m], "pull");
    end
    ext_level[0] <= 0;
    repeat (4) @(posedge clk);
    check({pad_drive[0].pull_up_en, pad_drive[0].pull_down_en}, 2'h1, "repeat low");
    ext_en[0] <= 0;
    repeat (4) @(posedge clk);
    check(pad_in[0], 1'b0, "repeat hold");
    analog_select[0] <= 1;
    repeat (2) @(posedge clk);
    check({pad_drive[0].analog_mode, pad_drive[0].drive_oe_b}, 2'h3, "analog");
    analog_select[0] <= 0;
    $display("test pulls done");
    // pseudo open-drain against push-pull
    apb(1, OFF_CFG_P0_N0, 32'h1 << POD_BIT);
    func_req[0] <= '{out_level: 1'b1, out_enable: 1'b1};
    repeat (2) @(posedge clk);
    check(pad_drive[0].drive_oe_b, 1'b1, "pod high");
    func_req[0].out_level <= 0;
    repeat (2) @(posedge clk);
    check({pad_drive[0].drive_level, pad_drive[0].drive_oe_b}, 2'h0, "pod low");
    apb(1, OFF_CFG_P0_N0, '0);
    func_req[0].out_level <= 1;
    repeat (2) @(posedge clk);
    check({pad_drive[0].drive_level, pad_drive[0].drive_oe_b}, 2'h2, "push high");
    func_req[0] <= '0;
    // bus pad 10 parked low by its function
    func_req[10] <= '{out_level: 1'b0, out_enable: 1'b1};
    repeat (2) @(posedge clk);
    check({pad_drive[10].drive_level, pad_drive[10].drive_oe_b}, 2'h0, "bus park");
    func_req[10] <= '0;
    // inverted bypass follows the pin at once
    apb(1, OFF_CFG_P0_N0, 32'h1 << INV_BIT);
    ext_en[0] <= 1; ext_level[0] <= 1;
    @(posedge clk);
    @(posedge clk);
    check(core_in[0], 1'b0, "invert");
    ext_level[0] <= 0;
    @(posedge clk);
    @(posedge clk);
    check(core_in[0], 1'b1, "bypass");
    $display("test drive done");
    // filter: each clock select, counts 1 to 3, both polarities
    cur = 0;
    for (int c = 0; c < NUM_FCLK; c++) begin
      s = c % 3 + 1;
      p = 4 * (c + 1);
      apb(1, OFF_CFG_P0_N0, (32'(s) << SMODE_LSB) | (32'(c) << CDIV_LSB));
      repeat (4 * p) @(posedge clk);
      bad = 0;
      ext_level[0] <= !cur;
      mon(s * p - p / 2, cur);
      ext_level[0] <= cur;
      mon((s + 2) * p, cur);
      check(bad, 1'b0, "glitch rejected");
      ext_level[0] <= !cur;
      mon(s * p - 1, cur);
      check(bad, 1'b0, "early pass");
      repeat (3 * p) @(posedge clk);
      check(core_in[0], !cur, "level passed");
      cur = !cur;
    end
    $display("test filter done");
    print_verdict();
  end
endmodule : pad_config_unit_tb
`default_nettype wire
